// ===== pkg/iert_pkg.sv
// package: constants and types for the interrupt entry, return and clock block
package iert_pkg;
  localparam int IERT_ADDR_W = 15;
  localparam int IERT_WORD_W = 48;
  localparam int IERT_HALF_W = 24;
  localparam logic [14:0] IERT_INTERNAL_VEC = 15'h0007;
  localparam logic [14:0] IERT_EXT_VEC_BASE = 15'h0008;
  localparam logic [14:0] IERT_EXT_VEC_LAST = 15'h000f;
  localparam logic [14:0] IERT_CLOCK_ADDR = 15'h0000;
  localparam logic [23:0] IERT_EXF_CLOCK_START = 24'hf00200;
  localparam logic [23:0] IERT_EXF_CLOCK_STOP = 24'hf00400;
  localparam int IERT_VEC_FORCE_BIT = 3;
  localparam int IERT_CHANNELS = 8;
  localparam int IERT_TICK_US_NUM = 50000;
  localparam int IERT_TICK_US_DEN = 3;
  localparam int IERT_CLK_MHZ = 100;
  localparam int IERT_TICK_CYCLES = (IERT_TICK_US_NUM * IERT_CLK_MHZ) / IERT_TICK_US_DEN;
  localparam int IERT_TICK_W = 24;

  typedef enum logic [3:0] {
    IERT_IDLE     = 4'h0,
    IERT_ENTER    = 4'h1,
    IERT_STORE    = 4'h2,
    IERT_WAIT_WR  = 4'h3,
    IERT_HALF_EX  = 4'h4,
    IERT_RET_RD   = 4'h5,
    IERT_RET_DONE = 4'h6,
    IERT_RET_FIX  = 4'h7,
    IERT_CLK_RD   = 4'h8,
    IERT_CLK_WR   = 4'h9,
    IERT_CLK_EXIT = 4'ha
  } iert_state_t;
endpackage

// ===== pkg/iert_mem_if.sv
// interface: storage request carrier between controller and store port
`timescale 1ns/1ps
`default_nettype none
interface iert_mem_if;
  import iert_pkg::*;
  logic req;
  logic we;
  logic upper_only;
  logic [IERT_ADDR_W-1:0] addr;
  logic [IERT_WORD_W-1:0] wdata;
  logic done;
  logic [IERT_WORD_W-1:0] rdata;
  modport ctl (output req, output we, output upper_only, output addr, output wdata, input done, input rdata);
  modport port (input req, input we, input upper_only, input addr, input wdata, output done, output rdata);
endinterface
`default_nettype wire

// ===== design/iert_store_port.sv
// store port: registers one storage request toward main storage
`timescale 1ns/1ps
`default_nettype none
module iert_store_port
  import iert_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // controller side
  iert_mem_if.port mem,
  // main storage side
  output logic st_req,
  output logic st_we,
  output logic st_upper_only,
  output logic [IERT_ADDR_W-1:0] st_addr,
  output logic [IERT_WORD_W-1:0] st_wdata,
  input wire logic st_ack,
  input wire logic [IERT_WORD_W-1:0] st_rdata
);
  logic busy, next_busy;
  logic done, next_done;
  logic [IERT_WORD_W-1:0] rdata, next_rdata;
  logic next_we, next_upper;
  logic [IERT_ADDR_W-1:0] next_addr;
  logic [IERT_WORD_W-1:0] next_wdata;

  always_comb begin
    next_busy = busy;
    next_done = 1'b0;
    next_rdata = rdata;
    next_we = st_we;
    next_upper = st_upper_only;
    next_addr = st_addr;
    next_wdata = st_wdata;
    if (!busy && mem.req) begin
      next_busy = 1'b1;
      next_we = mem.we;
      next_upper = mem.upper_only;
      next_addr = mem.addr;
      next_wdata = mem.wdata;
    end else if (busy && st_ack) begin
      next_busy = 1'b0;
      next_done = 1'b1;
      next_rdata = st_rdata;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= '0;
      st_we <= 1'b0;
      st_upper_only <= 1'b0;
      st_addr <= '0;
      st_wdata <= '0;
    end else begin
      busy <= next_busy;
      done <= next_done;
      rdata <= next_rdata;
      st_we <= next_we;
      st_upper_only <= next_upper;
      st_addr <= next_addr;
      st_wdata <= next_wdata;
    end
  end

  assign st_req = busy;
  assign mem.done = done;
  assign mem.rdata = rdata;
endmodule
`default_nettype wire

// ===== design/iert_ctrl.sv
// top: interrupt entry, return to main program and real-time clock control
`timescale 1ns/1ps
`default_nettype none
module iert_ctrl
  import iert_pkg::*;
#(
  parameter int TICK_CYCLES = IERT_TICK_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // sequencing control
  input wire logic seq_exit,
  input wire logic fetch_active,
  input wire logic fetch_upper_read,
  input wire logic [IERT_ADDR_W-1:0] fetch_addr,
  input wire logic ret_jump_done,
  input wire logic [IERT_ADDR_W-1:0] program_addr,
  input wire logic exit_flag_in,
  // request sources
  input wire logic internal_request,
  input wire logic external_request,
  input wire logic [2:0] vector_source_register,
  // function code strobe
  input wire logic exf_strobe,
  input wire logic [23:0] exf_code,
  // control outputs
  output logic seq_active,
  output logic fetch_inhibit,
  output logic fetch_restart,
  output logic half_exit,
  output logic jump_exit,
  output logic [IERT_ADDR_W-1:0] next_program_addr,
  output logic load_program_addr,
  output logic [IERT_HALF_W-1:0] upper_instruction,
  output logic load_upper_instruction,
  output logic input_transfer_clear,
  output logic [IERT_CHANNELS-1:0] masked_request_clear,
  output logic external_request_clear,
  output logic interrupt_lockout_flag,
  output logic interrupt_complete_flag,
  output logic interrupt_exit_flag,
  output logic exit_flag,
  output logic wait_storage_flag,
  output logic clock_running_flag,
  output logic advance_clock_flag,
  output logic return_jump_flag,
  output logic internal_class_flag,
  output logic external_class_flag,
  // main storage
  output logic st_req,
  output logic st_we,
  output logic st_upper_only,
  output logic [IERT_ADDR_W-1:0] st_addr,
  output logic [IERT_WORD_W-1:0] st_wdata,
  input wire logic st_ack,
  input wire logic [IERT_WORD_W-1:0] st_rdata
);
  // refuse tick counts the counter cannot hold
  if (TICK_CYCLES < 2 || TICK_CYCLES >= (1 << IERT_TICK_W)) begin : g_tick_check
    $error("tick count out of range");
  end

  iert_mem_if mem();
  iert_store_port u_port (
    .ref_clk(ref_clk), .reset_n(reset_n), .mem(mem),
    .st_req(st_req), .st_we(st_we), .st_upper_only(st_upper_only), .st_addr(st_addr),
    .st_wdata(st_wdata), .st_ack(st_ack), .st_rdata(st_rdata)
  );

  // ----------------------------------------
  // state and registers
  // ----------------------------------------
  iert_state_t state, next_state;
  logic [IERT_TICK_W-1:0] tick, next_tick;
  logic clock_req, next_clock_req;
  logic [IERT_WORD_W-1:0] operand, next_operand;
  logic [IERT_ADDR_W-1:0] saved_p, next_saved_p;
  logic [IERT_ADDR_W-1:0] vector, next_vector;
  logic mreq, next_mreq, mwe, next_mwe, mupper, next_mupper;
  logic [IERT_ADDR_W-1:0] maddr, next_maddr;
  logic next_seq_active, next_fetch_inhibit, next_fetch_restart, next_half_exit, next_jump_exit;
  logic [IERT_ADDR_W-1:0] next_npa;
  logic next_load_pa, next_load_ui, next_itc, next_erc;
  logic [IERT_HALF_W-1:0] next_ui;
  logic [IERT_CHANNELS-1:0] next_mrc;
  logic next_lock, next_cmpl, next_iexit, next_exit, next_wait, next_run, next_adv, next_rj;
  logic next_icls, next_ecls;
  logic recognise;

  assign mem.req = mreq;
  assign mem.we = mwe;
  assign mem.upper_only = mupper;
  assign mem.addr = maddr;
  assign mem.wdata = operand;

  // clock waits for fetch
  // clock request may not break into a fetch; interrupts may at exits
  assign recognise = seq_exit && !fetch_active;

  always_comb begin
    next_state = state;
    next_tick = tick;
    next_clock_req = clock_req;
    next_operand = operand;
    next_saved_p = saved_p;
    next_vector = vector;
    next_mreq = 1'b0;
    next_mwe = mwe;
    next_mupper = mupper;
    next_maddr = maddr;
    next_seq_active = 1'b1;
    next_fetch_inhibit = 1'b0;
    next_fetch_restart = 1'b0;
    next_half_exit = 1'b0;
    next_jump_exit = 1'b0;
    next_npa = next_program_addr;
    next_load_pa = 1'b0;
    next_ui = upper_instruction;
    next_load_ui = 1'b0;
    next_itc = 1'b0;
    next_erc = 1'b0;
    next_mrc = '0;
    next_lock = interrupt_lockout_flag;
    next_cmpl = interrupt_complete_flag;
    next_iexit = interrupt_exit_flag;
    next_exit = exit_flag;
    next_wait = wait_storage_flag;
    next_run = clock_running_flag;
    next_adv = advance_clock_flag;
    next_rj = return_jump_flag;
    next_icls = internal_class_flag;
    next_ecls = external_class_flag;
    if (exf_strobe && exf_code == IERT_EXF_CLOCK_START) next_run = 1'b1;
    if (exf_strobe && exf_code == IERT_EXF_CLOCK_STOP) next_run = 1'b0;
    if (clock_running_flag) begin
      if (tick == IERT_TICK_W'(TICK_CYCLES - 1)) begin
        next_tick = '0;
        next_clock_req = 1'b1;
      end else begin
        next_tick = tick + 1'b1;
      end
    end else begin
      next_tick = '0;
    end
    unique case (state)
      IERT_IDLE: begin
        next_seq_active = 1'b0;
        if (recognise && clock_req) begin
          next_state = IERT_CLK_RD;
          next_adv = 1'b1;
          next_operand = '0;
          next_exit = ~exit_flag_in;
          next_fetch_inhibit = 1'b1;
          next_seq_active = 1'b1;
          next_mreq = 1'b1;
          next_mwe = 1'b0;
          next_mupper = 1'b0;
          next_maddr = IERT_CLOCK_ADDR;
        end else if (seq_exit && !interrupt_lockout_flag && (internal_request || external_request)) begin
          next_state = IERT_ENTER;
          next_itc = 1'b1;
          next_operand = '0;
          next_icls = internal_request;
          next_ecls = !internal_request;
          next_saved_p = program_addr;
          next_fetch_inhibit = 1'b1;
          next_seq_active = 1'b1;
        end else if (interrupt_complete_flag && ret_jump_done) begin
          next_state = IERT_RET_RD;
          next_wait = 1'b1;
          next_exit = 1'b1;
          next_seq_active = 1'b1;
          next_mreq = 1'b1;
          next_mwe = 1'b0;
          next_mupper = 1'b0;
          next_maddr = program_addr;
        end
      end
      IERT_ENTER: begin
        if (external_class_flag)
          next_vector = {12'h000, vector_source_register} | (15'h0001 << IERT_VEC_FORCE_BIT);
        else
          next_vector = IERT_INTERNAL_VEC;
        next_state = IERT_STORE;
      end
      IERT_STORE: begin
        next_lock = 1'b1;
        if (external_class_flag) next_mrc[vector_source_register] = 1'b1;
        next_erc = 1'b1;
        if (internal_class_flag) next_ecls = 1'b0;
        next_iexit = exit_flag_in;
        next_rj = 1'b1;
        next_wait = 1'b1;
        next_operand = {9'h000, saved_p, 24'h000000};
        next_npa = vector;
        next_load_pa = 1'b1;
        next_mreq = 1'b1;
        next_mwe = 1'b1;
        next_mupper = 1'b1;
        next_maddr = vector;
        next_state = IERT_WAIT_WR;
      end
      IERT_WAIT_WR: begin
        if (mem.done) begin
          next_wait = 1'b0;
          next_ui = mem.rdata[IERT_HALF_W-1:0];
          next_state = IERT_HALF_EX;
        end
      end
      IERT_HALF_EX: begin
        next_load_ui = 1'b1;
        next_half_exit = 1'b1;
        next_rj = 1'b0;
        next_state = IERT_IDLE;
      end
      IERT_RET_RD: begin
        if (mem.done) begin
          next_ui = mem.rdata[IERT_WORD_W-1:IERT_HALF_W];
          next_operand = mem.rdata;
          next_load_ui = 1'b1;
          next_lock = 1'b0;
          next_cmpl = 1'b0;
          next_state = IERT_RET_DONE;
        end
      end
      IERT_RET_DONE: begin
        if (interrupt_exit_flag) begin
          next_wait = 1'b0;
          next_state = IERT_IDLE;
        end else begin
          next_fetch_inhibit = 1'b1;
          next_wait = 1'b0;
          next_exit = 1'b0;
          next_state = IERT_RET_FIX;
        end
      end
      IERT_RET_FIX: begin
        next_ui = operand[IERT_HALF_W-1:0];
        next_load_ui = 1'b1;
        next_fetch_restart = 1'b1;
        next_state = IERT_IDLE;
      end
      IERT_CLK_RD: begin
        if (mem.done) begin
          next_operand = mem.rdata + 1'b1;
          next_clock_req = 1'b0;
          next_mreq = 1'b1;
          next_mwe = 1'b1;
          next_mupper = 1'b0;
          next_state = IERT_CLK_WR;
        end
      end
      IERT_CLK_WR: begin
        if (mem.done) next_state = IERT_CLK_EXIT;
      end
      IERT_CLK_EXIT: begin
        // exit by exit flag, address untouched
        if (exit_flag) next_jump_exit = 1'b1;
        else next_half_exit = 1'b1;
        next_adv = 1'b0;
        next_state = IERT_IDLE;
      end
      default: next_state = IERT_IDLE;
    endcase
    // vector word upper read
    // placed after the return clear so a coinciding set wins
    if (fetch_upper_read && fetch_addr >= IERT_INTERNAL_VEC && fetch_addr <= IERT_EXT_VEC_LAST)
      next_cmpl = 1'b1;
    // a tick landing on the clearing edge is kept
    if (clock_running_flag && tick == IERT_TICK_W'(TICK_CYCLES - 1)) next_clock_req = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= IERT_IDLE;
      tick <= '0;
      clock_req <= 1'b0;
      operand <= '0;
      saved_p <= '0;
      vector <= '0;
      mreq <= 1'b0;
      mwe <= 1'b0;
      mupper <= 1'b0;
      maddr <= '0;
      seq_active <= 1'b0;
      fetch_inhibit <= 1'b0;
      fetch_restart <= 1'b0;
      half_exit <= 1'b0;
      jump_exit <= 1'b0;
      next_program_addr <= '0;
      load_program_addr <= 1'b0;
      upper_instruction <= '0;
      load_upper_instruction <= 1'b0;
      input_transfer_clear <= 1'b0;
      masked_request_clear <= '0;
      external_request_clear <= 1'b0;
      interrupt_lockout_flag <= 1'b0;
      interrupt_complete_flag <= 1'b0;
      interrupt_exit_flag <= 1'b0;
      exit_flag <= 1'b0;
      wait_storage_flag <= 1'b0;
      clock_running_flag <= 1'b0;
      advance_clock_flag <= 1'b0;
      return_jump_flag <= 1'b0;
      internal_class_flag <= 1'b0;
      external_class_flag <= 1'b0;
    end else begin
      state <= next_state;
      tick <= next_tick;
      clock_req <= next_clock_req;
      operand <= next_operand;
      saved_p <= next_saved_p;
      vector <= next_vector;
      mreq <= next_mreq;
      mwe <= next_mwe;
      mupper <= next_mupper;
      maddr <= next_maddr;
      seq_active <= next_seq_active;
      fetch_inhibit <= next_fetch_inhibit;
      fetch_restart <= next_fetch_restart;
      half_exit <= next_half_exit;
      jump_exit <= next_jump_exit;
      next_program_addr <= next_npa;
      load_program_addr <= next_load_pa;
      upper_instruction <= next_ui;
      load_upper_instruction <= next_load_ui;
      input_transfer_clear <= next_itc;
      masked_request_clear <= next_mrc;
      external_request_clear <= next_erc;
      interrupt_lockout_flag <= next_lock;
      interrupt_complete_flag <= next_cmpl;
      interrupt_exit_flag <= next_iexit;
      exit_flag <= next_exit;
      wait_storage_flag <= next_wait;
      clock_running_flag <= next_run;
      advance_clock_flag <= next_adv;
      return_jump_flag <= next_rj;
      internal_class_flag <= next_icls;
      external_class_flag <= next_ecls;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_store_step;
    state == IERT_STORE;
  endsequence
  AST_ENTRY_CLEARS: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state == IERT_ENTER |-> input_transfer_clear && operand == '0) else $error("entry clear missing");
  AST_STORE_UPPER: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_store_step |=> mreq && mwe && mupper && return_jump_flag) else $error("upper write missing");
  AST_VECTOR_RANGE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state == IERT_STORE |-> vector >= IERT_INTERNAL_VEC && vector <= IERT_EXT_VEC_LAST)
    else $error("vector out of range");
  AST_INTERNAL_VEC: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state == IERT_STORE && internal_class_flag |-> vector == IERT_INTERNAL_VEC) else $error("internal vector");
  AST_LOCKOUT: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_store_step |=> interrupt_lockout_flag && external_request_clear) else $error("lockout not set");
  AST_HALF_EXIT: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state == IERT_HALF_EX |=> half_exit && load_upper_instruction) else $error("half exit missing");
  AST_RETURN_CLEAR: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state == IERT_RET_RD && mem.done |=> !interrupt_lockout_flag && !interrupt_complete_flag)
    else $error("return clear missing");
  AST_RESTART: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state == IERT_RET_DONE && !interrupt_exit_flag |=> !exit_flag ##1 fetch_restart) else $error("restart");
  AST_CLOCK_INC: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state == IERT_CLK_RD && mem.done |=> operand == $past(mem.rdata) + 1'b1) else $error("clock add");
  AST_CLOCK_NO_P: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state == IERT_CLK_EXIT |=> (jump_exit ^ half_exit) && !load_program_addr) else $error("clock exit");
endmodule
`default_nettype wire

// ===== test/iert_store_model.sv
// main storage model answering the controller's storage requests
`timescale 1ns/1ps
`default_nettype none
module iert_store_model
  import iert_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // storage request
  input wire logic st_req,
  input wire logic st_we,
  input wire logic st_upper_only,
  input wire logic [IERT_ADDR_W-1:0] st_addr,
  input wire logic [IERT_WORD_W-1:0] st_wdata,
  // storage answer
  output logic st_ack,
  output logic [IERT_WORD_W-1:0] st_rdata
);
  logic [IERT_WORD_W-1:0] mem [16];
  int lat = 1;
  int cnt;
  int gap;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ack <= 1'b0;
      cnt <= 0;
      gap <= 0;
      st_rdata <= '1;
    end else begin
      st_ack <= 1'b0;
      // data lines carry nothing useful outside an answer
      st_rdata <= ~st_rdata;
      if (gap > 0) begin
        gap <= gap - 1;
      end else if (st_req && cnt < lat) begin
        cnt <= cnt + 1;
      end else if (st_req) begin
        cnt <= 0;
        gap <= 2;
        st_ack <= 1'b1;
        if (!st_we) begin
          st_rdata <= mem[st_addr[3:0]];
        end else if (st_upper_only) begin
          mem[st_addr[3:0]][47:24] <= st_wdata[47:24];
          // partial write hands back the merged word
          st_rdata <= {st_wdata[47:24], mem[st_addr[3:0]][23:0]};
        end else begin
          mem[st_addr[3:0]] <= st_wdata;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/testbench.sv
// testbench: interrupt entry, return and clock sequences against a storage model
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import iert_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic seq_exit, fetch_active, fetch_upper_read, ret_jump_done, exit_flag_in;
  logic internal_request, external_request, exf_strobe;
  logic [IERT_ADDR_W-1:0] fetch_addr, program_addr, next_program_addr, st_addr;
  logic [2:0] vector_source_register;
  logic [23:0] exf_code;
  logic seq_active, fetch_inhibit, fetch_restart, half_exit, jump_exit, load_program_addr;
  logic [IERT_HALF_W-1:0] upper_instruction;
  logic load_upper_instruction, input_transfer_clear, external_request_clear;
  logic [IERT_CHANNELS-1:0] masked_request_clear;
  logic interrupt_lockout_flag, interrupt_complete_flag, interrupt_exit_flag, exit_flag;
  logic wait_storage_flag, clock_running_flag, advance_clock_flag, return_jump_flag;
  logic internal_class_flag, external_class_flag;
  logic st_req, st_we, st_upper_only, st_ack;
  logic [IERT_WORD_W-1:0] st_wdata, st_rdata;
  int n_fail = 0;
  int samples_checked = 0;
  int ev [9];
  logic [IERT_ADDR_W-1:0] pa_seen;
  logic [IERT_CHANNELS-1:0] mrc_seen;
  logic [IERT_HALF_W-1:0] ui_seen;
  logic upo_seen, rj_seen, ws_seen;
  logic lock_q = 1'b0;

  always #5 ref_clk = ~ref_clk;

  iert_ctrl #(.TICK_CYCLES(20)) DUT (.*);
  iert_store_model stor (.*);

  // ------------------------------------------
  // event capture: one-cycle pulses, advance-clock cycles and lockout falls are counted
  // ------------------------------------------
  always @(posedge ref_clk) begin
    lock_q <= interrupt_lockout_flag;
    if (load_program_addr) begin
      ev[0] <= ev[0] + 1;
      pa_seen <= next_program_addr;
    end
    if (masked_request_clear != '0) mrc_seen <= masked_request_clear;
    if (half_exit) ev[1] <= ev[1] + 1;
    if (jump_exit) ev[2] <= ev[2] + 1;
    if (fetch_inhibit) ev[3] <= ev[3] + 1;
    if (fetch_restart) ev[4] <= ev[4] + 1;
    if (input_transfer_clear) ev[5] <= ev[5] + 1;
    if (lock_q && !interrupt_lockout_flag) ev[6] <= ev[6] + 1;
    if (advance_clock_flag) ev[7] <= ev[7] + 1;
    if (external_request_clear) ev[8] <= ev[8] + 1;
    if (load_upper_instruction) ui_seen <= upper_instruction;
    if (wait_storage_flag) ws_seen <= 1'b1;
    if (st_req && st_we) begin
      upo_seen <= st_upper_only;
      rj_seen <= return_jump_flag;
    end
  end

  task check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task wait_ev(input int k, input int j);
    for (int i = 0; i < 400 && ev[k] + ev[j] == 0; i++) @(negedge ref_clk);
  endtask

  task clr_ev();
    ev = '{default: 0};
    mrc_seen = '0;
    upo_seen = 1'b0;
    rj_seen = 1'b0;
    ws_seen = 1'b0;
  endtask

  task print_verdict();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task t_reset();
    check("idle lockout", interrupt_lockout_flag, 1'b0);
    check("idle outputs", {clock_running_flag, st_req, seq_active}, 3'h0);
  endtask

  task t_entry(input logic ext, input logic [2:0] ch, input logic [14:0] pa, input logic xin);
    logic [14:0] vec;
    vec = ext ? (IERT_EXT_VEC_BASE | {12'h0, ch}) : IERT_INTERNAL_VEC;
    stor.mem[vec[3:0]] = {24'h5a5a5a, 21'h0f0f0f, vec[2:0]};
    clr_ev();
    program_addr = pa;
    exit_flag_in = xin;
    vector_source_register = ch;
    internal_request = !ext;
    external_request = ext;
    seq_exit = 1'b1;
    wait_ev(0, 0);
    internal_request = 1'b0;
    external_request = 1'b0;
    seq_exit = 1'b0;
    wait_ev(1, 1);
    repeat (2) @(negedge ref_clk);
    check("vector", pa_seen, vec);
    check("lockout", interrupt_lockout_flag, 1'b1);
    check("class", {internal_class_flag, external_class_flag}, {!ext, ext});
    check("input transfer clear", ev[5] > 0, 1'b1);
    check("external request clear", ev[8] > 0, 1'b1);
    check("channel clear", mrc_seen, ext ? (8'h01 << ch) : 8'h00);
    check("interrupt exit", interrupt_exit_flag, xin);
    check("return jump", {rj_seen, upo_seen}, 2'h3);
    check("saved word", stor.mem[vec[3:0]][38:0], {pa, 21'h0f0f0f, vec[2:0]});
    check("half exit", ev[1], 1);
    check("upper instruction", ui_seen, {21'h0f0f0f, vec[2:0]});
    // a new request while locked out must be ignored
    ev[5] = 0;
    internal_request = 1'b1;
    seq_exit = 1'b1;
    repeat (30) @(negedge ref_clk);
    internal_request = 1'b0;
    seq_exit = 1'b0;
    check("locked out", ev[5], 0);
  endtask

  task t_return(input logic [14:0] vec, input logic [14:0] pa, input logic xin);
    stor.mem[pa[3:0]] = 48'h777777_666666;
    clr_ev();
    // first address past the vector block must not count
    fetch_addr = 15'h0010;
    fetch_upper_read = 1'b1;
    @(negedge ref_clk);
    check("complete past block", interrupt_complete_flag, 1'b0);
    fetch_addr = vec;
    @(negedge ref_clk);
    fetch_upper_read = 1'b0;
    check("complete", interrupt_complete_flag, 1'b1);
    program_addr = pa;
    ret_jump_done = 1'b1;
    @(negedge ref_clk);
    ret_jump_done = 1'b0;
    wait_ev(6, 6);
    repeat (6) @(negedge ref_clk);
    check("lockout cleared", ev[6], 1);
    check("complete cleared", interrupt_complete_flag, 1'b0);
    check("restart", ev[3] > 0 && ev[4] > 0, !xin);
    check("exit flag", exit_flag, xin);
    check("wait storage", {ws_seen, wait_storage_flag}, 2'h2);
  endtask

  task t_clock();
    stor.mem[0] = 48'h000000_ffffff;
    clr_ev();
    exit_flag_in = 1'b0;
    seq_exit = 1'b1;
    fetch_active = 1'b1;
    exf_code = IERT_EXF_CLOCK_START;
    exf_strobe = 1'b1;
    @(negedge ref_clk);
    exf_strobe = 1'b0;
    @(negedge ref_clk);
    check("clock running", clock_running_flag, 1'b1);
    repeat (50) @(negedge ref_clk);
    check("no entry during fetch", ev[7], 0);
    fetch_active = 1'b0;
    wait_ev(1, 2);
    seq_exit = 1'b0;
    exf_code = IERT_EXF_CLOCK_STOP;
    exf_strobe = 1'b1;
    @(negedge ref_clk);
    exf_strobe = 1'b0;
    repeat (3) @(negedge ref_clk);
    check("clock stopped", clock_running_flag, 1'b0);
    check("advance clock", ev[7] > 0, 1'b1);
    check("clock word", stor.mem[0], 48'h000001_000000);
    check("address kept", ev[0], 0);
    check("one exit", ev[1] + ev[2], 1);
    check("jump exit", ev[2], 1);
    check("exit complemented", exit_flag, 1'b1);
    repeat (80) @(negedge ref_clk);
    check("stopped word", stor.mem[0], 48'h000001_000000);
  endtask

  // ------------------------------------------
  // main sequence
  // ------------------------------------------
  initial begin
    {seq_exit, fetch_active, fetch_upper_read, ret_jump_done, exit_flag_in} = '0;
    {internal_request, external_request, exf_strobe} = '0;
    fetch_addr = '0;
    program_addr = '0;
    vector_source_register = '0;
    exf_code = '0;
    repeat (6) @(negedge ref_clk);
    reset_n = 1'b1;
    @(negedge ref_clk);
    t_reset();
    t_entry(1'b1, 3'h3, 15'h0004, 1'b1);
    t_return(15'h000b, 15'h0004, 1'b1);
    // slow storage for the rest of the run
    stor.lat = 6;
    t_entry(1'b0, 3'h0, 15'h0005, 1'b0);
    t_return(15'h0007, 15'h0005, 1'b0);
    t_entry(1'b1, 3'h7, 15'h0006, 1'b0);
    t_return(15'h000f, 15'h0006, 1'b0);
    t_clock();
    print_verdict();
  end

  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire
